// [hdl/aid_core.sv]
// Purpose: decode and execute add literal, add file, add with carry, AND literal
// Assumes: memory read data arrive one clock after memRdEn; bus per plain port
// Notes: one instruction cycle is five clocks, one per phase
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps

`include "aid_consts.svh"

// Overview of operation
// - add file sums accumulator and data byte
// - dest bit 0 to accumulator, 1 to file
// - access bit 1 takes bank register low 4 bits as upper address bits
// - extended, access 0, f<=95 uses indexed offset
// - add with carry adds carry flag too
// - add with carry decoded as 0010 00da
// - file adds update N, OV, C, DC, Z
// - AND literal result always to accumulator
// - AND literal decoded as 0000 1011
// - AND literal updates only N and Z
// - add literal adds immediate, all flags, one cycle
module aid_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  output logic instrReady,
  output logic [11:0] memAddr,
  output logic memRdEn,
  input wire logic [7:0] memRdData,
  output logic memWrEn,
  output logic [7:0] memWrData,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData
);
  import aid_pkg::*;

  typedef struct packed {
    aid_phase_e phase;
    aid_op_e op;
    logic [15:0] instr;
    logic [11:0] addr;
    logic [7:0] operand;
    logic [7:0] result;
    logic [4:0] flags;
    logic [4:0] flagMask;
    logic toFile;
    logic [7:0] acc;
    logic [7:0] status;
    logic [7:0] bank;
    logic [7:0] ctrl;
    logic [11:0] idx;
    logic [2:0] lastOp;
    logic unsupported;
    logic [7:0] rdData;
  } aid_state_s;

  aid_state_s s_q;
  aid_state_s s_d;

  logic [7:0] aluResult;
  logic aluC;
  logic aluDc;
  logic aluOv;
  logic aluN;
  logic aluZ;
  aid_alu_e aluOp;
  logic aluCin;

  // opcode classification
  function automatic aid_op_e decodeOp(input logic [15:0] word);
    if (word[15:8] == `AID_OPC_ADDLIT) begin
      decodeOp = AID_OP_ADDLIT;
    end else if (word[15:8] == `AID_OPC_ANDLIT) begin
      decodeOp = AID_OP_ANDLIT;
    end else if (word[15:10] == `AID_OPC_ADDFILE) begin
      decodeOp = AID_OP_ADDFILE;
    end else if (word[15:10] == `AID_OPC_ADDCARRY) begin
      decodeOp = AID_OP_ADDCARRY;
    end else begin
      decodeOp = AID_OP_NONE;
    end
  endfunction

  function automatic logic isFileOp(input aid_op_e op);
    isFileOp = (op == AID_OP_ADDFILE) || (op == AID_OP_ADDCARRY);
  endfunction

  // effective data memory address of a file operand
  function automatic logic [11:0] fileAddr(
    input logic [15:0] word,
    input logic [7:0] bankSel,
    input logic extOn,
    input logic [11:0] idxBase
  );
    logic [7:0] f;
    f = word[7:0];
    if (word[`AID_ACCESS_BIT]) begin
      fileAddr = {bankSel[3:0], f};
    end else if (extOn && (f <= `AID_ACCESS_SPLIT)) begin
      fileAddr = idxBase + {4'h0, f};
    end else if (f <= `AID_ACCESS_SPLIT) begin
      fileAddr = {`AID_ACCESS_LOW, f};
    end else begin
      fileAddr = {`AID_ACCESS_HIGH, f};
    end
  endfunction

  always_comb begin
    aluOp = (s_q.op == AID_OP_ANDLIT) ? AID_ALU_AND : AID_ALU_ADD;
    aluCin = (s_q.op == AID_OP_ADDCARRY) ? s_q.status[`AID_ST_C] : 1'b0;
  end

  aid_alu aid_alu_i (
    .aluOp(aluOp),
    .opA(s_q.acc),
    .opB(s_q.operand),
    .carryIn(aluCin),
    .result(aluResult),
    .carryOut(aluC),
    .digitCarryOut(aluDc),
    .overflowOut(aluOv),
    .negativeOut(aluN),
    .zeroOut(aluZ)
  );

  always_comb begin
    s_d = s_q;

    // register port writes; a same-cycle execution write below wins
    if (regWr) begin
      unique case (regAddr)
        `AID_REG_ACC: s_d.acc = regWrData;
        `AID_REG_STATUS: s_d.status = {3'b000, regWrData[4:0]};
        `AID_REG_BANK: s_d.bank = {4'h0, regWrData[3:0]};
        `AID_REG_CTRL: s_d.ctrl = {7'h00, regWrData[`AID_CTL_EXT]};
        `AID_REG_IDXL: s_d.idx[7:0] = regWrData;
        `AID_REG_IDXH: s_d.idx[11:8] = regWrData[3:0];
        `AID_REG_LASTOP: s_d.lastOp = s_q.lastOp;
        `AID_REG_ERR: begin
          if (regWrData[`AID_ERR_UNSUP]) begin
            s_d.unsupported = 1'b0;
          end
        end
      endcase
    end

    if (regRd) begin
      unique case (regAddr)
        `AID_REG_ACC: s_d.rdData = s_q.acc;
        `AID_REG_STATUS: s_d.rdData = s_q.status;
        `AID_REG_BANK: s_d.rdData = s_q.bank;
        `AID_REG_CTRL: s_d.rdData = s_q.ctrl;
        `AID_REG_IDXL: s_d.rdData = s_q.idx[7:0];
        `AID_REG_IDXH: s_d.rdData = {4'h0, s_q.idx[11:8]};
        `AID_REG_LASTOP: s_d.rdData = {5'h00, s_q.lastOp};
        `AID_REG_ERR: s_d.rdData = {7'h00, s_q.unsupported};
      endcase
    end

    unique case (s_q.phase)
      AID_IDLE: begin
        if (instrValid) begin
          s_d.instr = instrWord;
          s_d.phase = AID_DECODE;
        end
      end
      AID_DECODE: begin
        s_d.op = decodeOp(s_q.instr);
        s_d.toFile = isFileOp(decodeOp(s_q.instr))
                     && s_q.instr[`AID_DEST_BIT];
        s_d.addr = fileAddr(s_q.instr, s_q.bank, s_q.ctrl[`AID_CTL_EXT], s_q.idx);
        s_d.phase = AID_READ;
      end
      AID_READ: begin
        // literal operand here; file operand arrives from memory next clock
        s_d.operand = s_q.instr[7:0];
        s_d.phase = AID_PROCESS;
      end
      AID_PROCESS: begin
        if (isFileOp(s_q.op)) begin
          s_d.operand = memRdData;
        end
        s_d.phase = AID_WRITE;
      end
      AID_WRITE: begin
        s_d.result = aluResult;
        s_d.flags[`AID_ST_C] = aluC;
        s_d.flags[`AID_ST_DC] = aluDc;
        s_d.flags[`AID_ST_Z] = aluZ;
        s_d.flags[`AID_ST_OV] = aluOv;
        s_d.flags[`AID_ST_N] = aluN;
        s_d.lastOp = s_q.op;
        unique case (s_q.op)
          AID_OP_ADDLIT: begin
            s_d.acc = aluResult;
            s_d.status[4:0] = s_d.flags;
          end
          AID_OP_ANDLIT: begin
            s_d.acc = aluResult;
            s_d.status[`AID_ST_Z] = aluZ;
            s_d.status[`AID_ST_N] = aluN;
          end
          AID_OP_ADDFILE, AID_OP_ADDCARRY: begin
            if (!s_q.toFile) begin
              s_d.acc = aluResult;
            end
            s_d.status[4:0] = s_d.flags;
          end
          AID_OP_NONE: begin
            s_d.unsupported = 1'b1;
          end
          default: begin
            s_d.unsupported = 1'b1;
          end
        endcase
        s_d.phase = AID_IDLE;
      end
      default: begin
        s_d.phase = AID_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{
        phase: AID_IDLE,
        op: AID_OP_NONE,
        instr: 16'h0000,
        addr: 12'h000,
        operand: 8'h00,
        result: 8'h00,
        flags: 5'h00,
        flagMask: 5'h00,
        toFile: 1'b0,
        acc: `AID_RST_ACC,
        status: `AID_RST_STATUS,
        bank: `AID_RST_BANK,
        ctrl: `AID_RST_CTRL,
        idx: `AID_RST_IDX,
        lastOp: 3'h0,
        unsupported: 1'b0,
        rdData: 8'h00
      };
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    instrReady = (s_q.phase == AID_IDLE);
    memAddr = s_q.addr;
    memRdEn = (s_q.phase == AID_READ) && isFileOp(s_q.op);
    memWrEn = (s_q.phase == AID_WRITE) && s_q.toFile;
    memWrData = aluResult;
    regRdData = s_q.rdData;
  end

endmodule // aid_core

// [hdl/aid_consts.svh]
// Purpose: constants for the add and AND instruction decoder
// Assumes: included by bare name
// Notes: offsets are register indices on the plain register port
`ifndef AID_CONSTS_SVH
`define AID_CONSTS_SVH

// opcode patterns, upper bits of the 16-bit instruction word
`define AID_OPC_ADDLIT 8'h0F
`define AID_OPC_ANDLIT 8'h0B
`define AID_OPC_ADDFILE 6'h09
`define AID_OPC_ADDCARRY 6'h08

// instruction word fields
`define AID_DEST_BIT 9
`define AID_ACCESS_BIT 8

// addressing
`define AID_ACCESS_SPLIT 8'h5F
`define AID_ACCESS_HIGH 4'hF
`define AID_ACCESS_LOW 4'h0

// status flag positions
`define AID_ST_C 0
`define AID_ST_DC 1
`define AID_ST_Z 2
`define AID_ST_OV 3
`define AID_ST_N 4

// control and error bit positions
`define AID_CTL_EXT 0
`define AID_ERR_UNSUP 0

// register indices
`define AID_REG_ACC 3'h0
`define AID_REG_STATUS 3'h1
`define AID_REG_BANK 3'h2
`define AID_REG_CTRL 3'h3
`define AID_REG_IDXL 3'h4
`define AID_REG_IDXH 3'h5
`define AID_REG_LASTOP 3'h6
`define AID_REG_ERR 3'h7

// reset values
`define AID_RST_ACC 8'h00
`define AID_RST_STATUS 8'h00
`define AID_RST_BANK 8'h00
`define AID_RST_CTRL 8'h00
`define AID_RST_IDX 12'h000

`endif

// [hdl/aid_pkg.sv]
// Purpose: types for the add and AND instruction decoder
// Assumes: nothing
// Notes: phase codes follow the five-phase instruction cycle
package aid_pkg;

  typedef enum logic [2:0] {
    AID_IDLE = 3'b000,
    AID_DECODE = 3'b001,
    AID_READ = 3'b010,
    AID_PROCESS = 3'b011,
    AID_WRITE = 3'b100
  } aid_phase_e;

  typedef enum logic [2:0] {
    AID_OP_NONE = 3'b000,
    AID_OP_ADDLIT = 3'b001,
    AID_OP_ANDLIT = 3'b010,
    AID_OP_ADDFILE = 3'b011,
    AID_OP_ADDCARRY = 3'b100
  } aid_op_e;

  typedef enum logic {
    AID_ALU_ADD = 1'b0,
    AID_ALU_AND = 1'b1
  } aid_alu_e;

endpackage

// [hdl/aid_alu.sv]
// Purpose: 8-bit add / AND datapath with status flags
// Assumes: purely combinational
// Notes: carry-in is ignored for the AND result; carryOut, digitCarryOut and overflowOut still use the sum
`timescale 1ns/1ps

module aid_alu (
  input wire aid_pkg::aid_alu_e aluOp,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  output logic [7:0] result,
  output logic carryOut,
  output logic digitCarryOut,
  output logic overflowOut,
  output logic negativeOut,
  output logic zeroOut
);
  import aid_pkg::*;

  logic [8:0] sum;
  logic [4:0] lowSum;

  always_comb begin
    sum = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
    lowSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    if (aluOp == AID_ALU_AND) begin
      result = opA & opB;
    end else begin
      result = sum[7:0];
    end
    carryOut = sum[8];
    digitCarryOut = lowSum[4];
    overflowOut = (opA[7] == opB[7]) && (sum[7] != opA[7]);
    negativeOut = result[7];
    zeroOut = (result == 8'h00);
  end

endmodule // aid_alu

// [tb/aid_checker.sv]
// Purpose: port assertions for aid_core
// Assumes: one clock domain
// Notes: shadows bank and mode writes
`timescale 1ns/1ps
module aid_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  input wire logic instrReady,
  input wire logic [11:0] memAddr,
  input wire logic memRdEn,
  input wire logic memWrEn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr
);
  logic [3:0] bankQ;
  logic extQ;
  logic take;
  logic file;
  assign take = instrValid && instrReady;
  assign file = instrWord[15:10] inside {6'h08, 6'h09};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bankQ <= 4'h0;
      extQ <= 1'b0;
    end else if (regWr) begin
      if (regAddr == 3'h2) bankQ <= regWrData[3:0];
      if (regAddr == 3'h3) extQ <= regWrData[0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_cycle_len: assert property (take |=> !instrReady [*4] ##1 instrReady)
    else $error("instruction cycle length wrong");
  a_file_read: assert property (take && file |-> ##2 memRdEn)
    else $error("file read missing");
  a_lit_nomem: assert property (take && !file |=> (!memRdEn && !memWrEn) [*4])
    else $error("literal op touched memory");
  a_dest_write: assert property (take && file |-> ##4 (memWrEn == $past(instrWord[9], 4)))
    else $error("destination write wrong");
  a_bank_addr: assert property (take && file && instrWord[8]
    |-> ##2 memAddr == {bankQ, $past(instrWord[7:0], 2)})
    else $error("banked address wrong");
  a_access_addr: assert property (take && file && !instrWord[8] && !extQ
    |-> ##2 memAddr == {($past(instrWord[7:0], 2) > 8'h5F) ? 4'hF : 4'h0,
    $past(instrWord[7:0], 2)})
    else $error("access bank address wrong");
  a_wr_pulse: assert property (memWrEn |=> !memWrEn)
    else $error("write longer than one cycle");
  a_wr_after_rd: assert property (memWrEn |-> $past(memRdEn, 2))
    else $error("write without read");
  c_file_wr: cover property (take && file && instrWord[9]);
  c_and_lit: cover property (take && instrWord[15:8] == 8'h0B);
  c_indexed: cover property (take && file && !instrWord[8] && extQ);
endmodule // aid_checker

bind aid_core aid_checker aid_checker_i (.clock(clock), .rst(rst), .instrWord(instrWord),
  .instrValid(instrValid), .instrReady(instrReady), .memAddr(memAddr), .memRdEn(memRdEn),
  .memWrEn(memWrEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr));

// [tb/aid_mem_model.sv]
// Purpose: data memory beside aid_core
// Assumes: read data one clock after memRdEn
// Notes: idle bus shows inverse of last value
`timescale 1ns/1ps
module aid_mem_model (
  input wire logic clock,
  input wire logic [11:0] memAddr,
  input wire logic memRdEn,
  input wire logic memWrEn,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData
);
  logic [7:0] mem [0:4095];
  initial memRdData = 8'h00;
  always @(posedge clock) begin
    if (memRdEn) memRdData <= mem[memAddr];
    else memRdData <= ~memRdData;
    if (memWrEn) mem[memAddr] <= memWrData;
  end
endmodule // aid_mem_model

// [tb/aid_core_test.sv]
// Purpose: self-checking bench for aid_core
// Assumes: aid_mem_model as data memory
// Notes: status preset before each literal and file op
`timescale 1ns/1ps
module aid_core_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instrWord = 16'h0000;
  logic instrValid = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic instrReady, memRdEn, memWrEn;
  logic [11:0] memAddr;
  logic [7:0] memRdData, memWrData, regRdData;
  int fails = 0;
  int n_checks = 0;
  always #50 clock = ~clock;
  aid_core aid_core_i (.clock(clock), .rst(rst), .instrWord(instrWord),
    .instrValid(instrValid), .instrReady(instrReady), .memAddr(memAddr), .memRdEn(memRdEn),
    .memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  aid_mem_model aid_mem_model_i (.clock(clock), .memAddr(memAddr), .memRdEn(memRdEn),
    .memWrEn(memWrEn), .memWrData(memWrData), .memRdData(memRdData));
  task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic regW(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic regR(input logic [2:0] a, input logic [7:0] e, input string nm);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    check8(nm, e, regRdData);
  endtask
  task automatic run(input logic [15:0] w);
    int i;
    @(posedge clock);
    instrValid <= 1'b1;
    instrWord <= w;
    @(posedge clock);
    instrValid <= 1'b0;
    i = 0;
    do begin
      @(negedge clock);
      i++;
    end while (instrReady !== 1'b1 && i < 12);
    check8("cycles", 8'h05, 8'(i));
  endtask
  task automatic lit(input logic [7:0] op, st0, acc, k, res, st);
    regW(3'h1, st0);
    regW(3'h0, acc);
    run({op, k});
    regR(3'h0, res, "acc");
    regR(3'h1, st, "status");
  endtask
  task automatic fop(input logic [15:0] w, input logic [7:0] st0, acc,
    input logic [11:0] ad, input logic [7:0] mv, res, st);
    regW(3'h1, st0);
    regW(3'h0, acc);
    aid_mem_model_i.mem[ad] = mv;
    run(w);
    regR(3'h1, st, "status");
    regR(3'h0, w[9] ? acc : res, "acc");
    check8("mem", w[9] ? res : mv, aid_mem_model_i.mem[ad]);
  endtask
  task automatic t_literal;
    lit(8'h0F, 8'h1F, 8'h10, 8'h15, 8'h25, 8'h00);
    lit(8'h0F, 8'h00, 8'h7F, 8'h01, 8'h80, 8'h1A);
    lit(8'h0F, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h07);
    lit(8'h0B, 8'h0B, 8'hA3, 8'h5F, 8'h03, 8'h0B);
    lit(8'h0B, 8'h1F, 8'hF0, 8'h0F, 8'h00, 8'h0F);
    lit(8'h0B, 8'h00, 8'h80, 8'hFF, 8'h80, 8'h10);
  endtask
  task automatic t_file;
    regW(3'h2, 8'h02);
    fop(16'h25C2, 8'h00, 8'h17, 12'h2C2, 8'hC2, 8'hD9, 8'h10);
    fop(16'h2610, 8'h00, 8'h80, 12'h010, 8'h80, 8'h00, 8'h0D);
    fop(16'h214D, 8'h01, 8'h02, 12'h24D, 8'h4D, 8'h50, 8'h02);
    fop(16'h2270, 8'h01, 8'hFF, 12'hF70, 8'h00, 8'h00, 8'h07);
  endtask
  task automatic t_indexed;
    regW(3'h3, 8'h01);
    regW(3'h4, 8'h34);
    regW(3'h5, 8'h01);
    fop(16'h265F, 8'h00, 8'h01, 12'h193, 8'h01, 8'h02, 8'h00);
    fop(16'h2660, 8'h00, 8'h01, 12'hF60, 8'h01, 8'h02, 8'h00);
    regW(3'h3, 8'h00);
  endtask
  task automatic t_unsup;
    regW(3'h0, 8'h5A);
    run(16'h0E33);
    regR(3'h0, 8'h5A, "acc");
    regR(3'h7, 8'h01, "err");
    regW(3'h7, 8'h01);
    regR(3'h7, 8'h00, "err");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_literal;
    t_file;
    t_indexed;
    t_unsup;
    report_and_stop;
  end
endmodule // aid_core_test
